// ### uss_top.sv
`default_nettype none
// Contract
// - Halving halfword subtract: two 16-bit differences, each shifted right one.
// - Halving byte subtract: four 8-bit differences, each shifted right one.
// - Halving forms and both abs-diff sums leave all flags unchanged.
// - Omitted destination writes the first operand register, except accumulate sum.
// - Register write and flag update happen only when the condition passes.
// - Abs-diff sum adds absolute values of four byte differences.
// - Accumulate form adds the accumulate register value to that sum.
// - Halfword subtract keeps low 16 bits of each lane difference.
// - Halfword subtract sets flag pairs 11 when lane non-negative, else 00.
// - Byte subtract keeps low eight bits of each of four lanes.
// - Byte subtract sets flag bit n when lane n is non-negative.
module uss_top
	import uss_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst_n,
	// Issue from the decoder.
	input wire logic issue,
	input wire logic [2:0] op_sel,
	input wire logic cond_pass,
	input wire logic dest_given,
	input wire logic [3:0] dest_reg,
	input wire logic [3:0] first_operand_reg,
	input wire logic [3:0] second_operand_reg,
	input wire logic [3:0] accumulate_reg,
	input wire logic [31:0] op_a,
	input wire logic [31:0] op_b,
	input wire logic [31:0] op_acc,
	// Register file write-back.
	output logic wr_en_r,
	output logic [3:0] wr_reg_r,
	output logic [31:0] wr_data_r,
	// Lane compare flag update.
	output logic flag_wr_r,
	output logic [3:0] lane_compare_flags_r
);
	logic [8:0] bdiff [USS_NLANE];
	logic [7:0] babs [USS_NLANE];
	logic [31:0] hbsub_res;
	logic [31:0] bsub_res;
	logic [3:0] bflag;

	// Byte lanes share one subtractor each; all byte forms reuse them.
	genvar gi;
	generate
		for (gi = 0; gi < USS_NLANE; gi++) begin : g_lane
			uss_lane_sub u_lane (
				.a(op_a[gi*8 +: 8]),
				.b(op_b[gi*8 +: 8]),
				.diff(bdiff[gi]),
				.absd(babs[gi])
			);
			assign hbsub_res[gi*8 +: 8] = bdiff[gi][8:1];
			assign bsub_res[gi*8 +: 8] = bdiff[gi][7:0];
			assign bflag[gi] = ~bdiff[gi][8];
		end
	endgenerate

	// Halfword lanes with the borrow kept as bit 16.
	wire [16:0] hdiff_lo = {1'b0, op_a[15:0]} - {1'b0, op_b[15:0]};
	wire [16:0] hdiff_hi = {1'b0, op_a[31:16]} - {1'b0, op_b[31:16]};
	wire [31:0] hhsub_res = {hdiff_hi[16:1], hdiff_lo[16:1]};
	wire [31:0] hsub_res = {hdiff_hi[15:0], hdiff_lo[15:0]};
	wire [3:0] hflag = {{2{~hdiff_hi[16]}}, {2{~hdiff_lo[16]}}};

	// abs sum. Ten bits suffice; zero-extend to the word.
	wire [9:0] sad_sum = 10'({2'b00, babs[0]} + {2'b00, babs[1]}
		+ {2'b00, babs[2]} + {2'b00, babs[3]});
	wire [31:0] sad_res = {22'h0, sad_sum};
	wire [31:0] sada_res = op_acc + sad_res;

	// Result selection; unknown codes produce no write.
	wire op_known = (op_sel <= USS_OP_BSUB);
	wire [31:0] res_sel = (op_sel == USS_OP_HHSUB) ? hhsub_res :
		(op_sel == USS_OP_HBSUB) ? hbsub_res :
		(op_sel == USS_OP_SAD) ? sad_res :
		(op_sel == USS_OP_SADA) ? sada_res :
		(op_sel == USS_OP_HSUB) ? hsub_res : bsub_res;
	wire sets_flags = (op_sel == USS_OP_HSUB) || (op_sel == USS_OP_BSUB);
	wire [3:0] flag_sel = (op_sel == USS_OP_HSUB) ? hflag : bflag;
	wire [3:0] dest_sel = (dest_given || op_sel == USS_OP_SADA) ? dest_reg : first_operand_reg;
	wire commit = issue && cond_pass && op_known;

	// Write-back stage; one registered cycle keeps the adder path off the port.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_en_r <= 1'b0;
			wr_reg_r <= USS_REG_RST;
			wr_data_r <= USS_RESULT_RST;
			flag_wr_r <= 1'b0;
		end else begin
			wr_en_r <= commit;
			wr_reg_r <= commit ? dest_sel : wr_reg_r;
			wr_data_r <= commit ? res_sel : wr_data_r;
			flag_wr_r <= commit && sets_flags;
		end
	end

	// Flags hold their value unless a passing plain subtract updates them.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lane_compare_flags_r <= USS_FLAG_RST;
		end else if (commit && sets_flags) begin
			lane_compare_flags_r <= flag_sel;
		end
	end

	// Reference sum built without the lane subtractors, so a wiring slip there shows up.
	// reference sum.
	function automatic logic [31:0] abs_byte_sum(input logic [31:0] a, input logic [31:0] b);
		logic [31:0] acc;
		logic [7:0] x;
		logic [7:0] y;
		acc = 32'h0;
		for (int i = 0; i < USS_NLANE; i++) begin
			x = a[i*8 +: 8];
			y = b[i*8 +: 8];
			acc = acc + 32'((x >= y) ? (x - y) : (y - x));
		end
		return acc;
	endfunction

	// Checks.
	property p_cond_gate;
		@(posedge sys_clk) disable iff (!rst_n)
		(issue && !cond_pass) |=> (!wr_en_r && !flag_wr_r);
	endproperty
	a_cond_gate: assert property (p_cond_gate) else $error("write despite failed condition");

	property p_flags_hold;
		@(posedge sys_clk) disable iff (!rst_n)
		!(issue && cond_pass && sets_flags) |=> $stable(lane_compare_flags_r);
	endproperty
	a_flags_hold: assert property (p_flags_hold) else $error("flags changed unexpectedly");

	property p_hhsub;
		@(posedge sys_clk) disable iff (!rst_n)
		(commit && op_sel == USS_OP_HHSUB) |=>
		wr_data_r[15:0] == 16'(({1'b0, $past(op_a[15:0])}
			- {1'b0, $past(op_b[15:0])}) >> 1)
		&& wr_data_r[31:16] == 16'(({1'b0, $past(op_a[31:16])}
			- {1'b0, $past(op_b[31:16])}) >> 1);
	endproperty
	a_hhsub: assert property (p_hhsub) else $error("halving halfword result wrong");

	property p_hbsub_lane0;
		@(posedge sys_clk) disable iff (!rst_n)
		(commit && op_sel == USS_OP_HBSUB) |=>
		wr_data_r[7:0] == 8'(({1'b0, $past(op_a[7:0])} - {1'b0, $past(op_b[7:0])}) >> 1);
	endproperty
	a_hbsub_lane0: assert property (p_hbsub_lane0) else $error("halving byte lane 0 wrong");

	property p_default_dest;
		@(posedge sys_clk) disable iff (!rst_n)
		(commit && !dest_given && op_sel != USS_OP_SADA) |=>
		wr_reg_r == $past(first_operand_reg);
	endproperty
	a_default_dest: assert property (p_default_dest) else $error("default destination wrong");

	property p_sad;
		@(posedge sys_clk) disable iff (!rst_n)
		(commit && op_sel == USS_OP_SAD) |=> wr_data_r == abs_byte_sum($past(op_a), $past(op_b));
	endproperty
	a_sad: assert property (p_sad) else $error("abs sum wrong");

	property p_sada;
		@(posedge sys_clk) disable iff (!rst_n)
		(commit && op_sel == USS_OP_SADA) |=>
		wr_data_r == 32'($past(op_acc) + abs_byte_sum($past(op_a), $past(op_b)));
	endproperty
	a_sada: assert property (p_sada) else $error("accumulate sum wrong");

	property p_hsub;
		@(posedge sys_clk) disable iff (!rst_n)
		(commit && op_sel == USS_OP_HSUB) |=>
		wr_data_r[15:0] == 16'($past(op_a[15:0]) - $past(op_b[15:0]));
	endproperty
	a_hsub: assert property (p_hsub) else $error("halfword subtract wrong");

	property p_hflag;
		@(posedge sys_clk) disable iff (!rst_n)
		(commit && op_sel == USS_OP_HSUB) |=>
		lane_compare_flags_r[1:0] == (($past(op_a[15:0]) >= $past(op_b[15:0])) ? 2'h3 : 2'h0);
	endproperty
	a_hflag: assert property (p_hflag) else $error("halfword flags wrong");

	property p_bsub;
		@(posedge sys_clk) disable iff (!rst_n)
		(commit && op_sel == USS_OP_BSUB) |=>
		wr_data_r[31:24] == 8'($past(op_a[31:24]) - $past(op_b[31:24]));
	endproperty
	a_bsub: assert property (p_bsub) else $error("byte subtract wrong");

	property p_bflag;
		@(posedge sys_clk) disable iff (!rst_n)
		(commit && op_sel == USS_OP_BSUB) |=>
		lane_compare_flags_r[3] == ($past(op_a[31:24]) >= $past(op_b[31:24]));
	endproperty
	a_bflag: assert property (p_bflag) else $error("byte flag wrong");

	property p_no_sp_pc;
		@(posedge sys_clk) disable iff (!rst_n)
		wr_en_r |-> (wr_reg_r != USS_REG_SP && wr_reg_r != USS_REG_PC);
	endproperty
	a_no_sp_pc: assert property (p_no_sp_pc) else $error("stack pointer or pc written");

	// Unused op codes are dropped silently: no strobe and the result word holds.
	property p_refused;
		@(posedge sys_clk) disable iff (!rst_n)
		(issue && op_sel > USS_OP_BSUB) |=> (!wr_en_r && !flag_wr_r && $stable(wr_data_r));
	endproperty
	a_refused: assert property (p_refused) else $error("unused op code wrote");
endmodule
`default_nettype wire

// ### uss_pkg.sv
`default_nettype none
// Shared constants for the packed unsigned subtract unit.
package uss_pkg;
	localparam int USS_DATA_W = 32;
	localparam int USS_REG_W = 4;
	localparam int USS_FLAG_W = 4;
	localparam int USS_BYTE_W = 8;
	localparam int USS_HALF_W = 16;
	localparam int USS_NLANE = 4;
	localparam logic [31:0] USS_RESULT_RST = 32'h0000_0000;
	localparam logic [3:0] USS_FLAG_RST = 4'h0;
	localparam logic [3:0] USS_REG_RST = 4'h0;
	// Operation select codes driven by the decoder.
	localparam logic [2:0] USS_OP_HHSUB = 3'h0;
	localparam logic [2:0] USS_OP_HBSUB = 3'h1;
	localparam logic [2:0] USS_OP_SAD = 3'h2;
	localparam logic [2:0] USS_OP_SADA = 3'h3;
	localparam logic [2:0] USS_OP_HSUB = 3'h4;
	localparam logic [2:0] USS_OP_BSUB = 3'h5;
	// Register numbers the decoder must never hand to this unit.
	localparam logic [3:0] USS_REG_SP = 4'hD;
	localparam logic [3:0] USS_REG_PC = 4'hF;
	// Result latency in clock edges from issue to write strobe.
	localparam int USS_LATENCY = 1;
endpackage
`default_nettype wire

// ### uss_lane_sub.sv
`default_nettype none
// One byte lane: nine-bit difference keeping the borrow, and its magnitude.
module uss_lane_sub
	import uss_pkg::*;
(
	// Lane operands.
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	// Lane results.
	output logic [8:0] diff,
	output logic [7:0] absd
);
	// Bit 8 set means a borrow, so the lane went negative.
	assign diff = {1'b0, a} - {1'b0, b};
	assign absd = diff[8] ? (b - a) : diff[7:0];
endmodule
`default_nettype wire

// ### uss_regfile_model.sv
`default_nettype none
// Register file behind the decoder: serves operands and takes the write-back.
module uss_regfile_model
	import uss_pkg::*;
(
	// Clock.
	input wire logic sys_clk,
	// Operand selects.
	input wire logic [3:0] first_operand_reg,
	input wire logic [3:0] second_operand_reg,
	input wire logic [3:0] accumulate_reg,
	// Write-back from the unit.
	input wire logic wr_en_r,
	input wire logic [3:0] wr_reg_r,
	input wire logic [31:0] wr_data_r,
	// Operand values.
	output logic [31:0] op_a,
	output logic [31:0] op_b,
	output logic [31:0] op_acc
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] rf [16];
	// Presets mix equal, larger and smaller lanes; register 3 forces a wrapping sum.
	initial begin
		for (int i = 0; i < 16; i++) begin
			rf[i] = 32'h0101_0101 * i;
		end
		rf[1] = 32'h0010_FF80;
		rf[2] = 32'hFFFF_0180;
		rf[3] = 32'hFFFF_FFF0;
	end
	// Reads are combinational, so operands are ready in the issue cycle.
	assign op_a = rf[first_operand_reg];
	assign op_b = rf[second_operand_reg];
	assign op_acc = rf[accumulate_reg];
	// Write-back lands on the edge after the one that raises the strobe.
	always @(posedge sys_clk) begin
		if (wr_en_r) begin
			rf[wr_reg_r] <= wr_data_r;
		end
	end
endmodule
`default_nettype wire

// ### tb.sv
`default_nettype none
// Self-checking bench for the packed unsigned subtract unit.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import uss_pkg::*;
	logic sys_clk, rst_n, issue, cond_pass, dest_given, wr_en_r, flag_wr_r;
	logic [2:0] op_sel;
	logic [3:0] dest_reg, first_operand_reg, second_operand_reg, accumulate_reg;
	logic [3:0] wr_reg_r, lane_compare_flags_r, ef;
	logic [31:0] op_a, op_b, op_acc, wr_data_r;
	int miscompares = 0;
	int n_compared = 0;
	uss_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .issue(issue), .op_sel(op_sel),
		.cond_pass(cond_pass), .dest_given(dest_given), .dest_reg(dest_reg),
		.first_operand_reg(first_operand_reg), .second_operand_reg(second_operand_reg),
		.accumulate_reg(accumulate_reg), .op_a(op_a), .op_b(op_b), .op_acc(op_acc),
		.wr_en_r(wr_en_r), .wr_reg_r(wr_reg_r), .wr_data_r(wr_data_r),
		.flag_wr_r(flag_wr_r), .lane_compare_flags_r(lane_compare_flags_r));
	uss_regfile_model rf_model (.sys_clk(sys_clk), .first_operand_reg(first_operand_reg),
		.second_operand_reg(second_operand_reg), .accumulate_reg(accumulate_reg),
		.wr_en_r(wr_en_r), .wr_reg_r(wr_reg_r), .wr_data_r(wr_data_r),
		.op_a(op_a), .op_b(op_b), .op_acc(op_acc));
	task automatic conclude();
		if (miscompares == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Reference lanes: differences are 17 bits wide so the borrow survives halving.
	task automatic calc(input logic [2:0] op, input logic [31:0] a, b, c,
		output logic [31:0] r, inout logic [3:0] f);
		int lw;
		logic [31:0] m;
		logic [16:0] x, y, d;
		lw = (op == USS_OP_HHSUB || op == USS_OP_HSUB) ? 16 : 8;
		m = (lw == 16) ? 32'h0000_FFFF : 32'h0000_00FF;
		r = (op == USS_OP_SADA) ? c : 32'h0;
		for (int i = 0; i < 32 / lw; i++) begin
			x = 17'((a >> (i * lw)) & m);
			y = 17'((b >> (i * lw)) & m);
			d = x - y;
			case (op)
				USS_OP_HHSUB, USS_OP_HBSUB: r |= ((32'(d) >> 1) & m) << (i * lw);
				USS_OP_HSUB: begin
					r |= (32'(d) & m) << (i * lw);
					f[2 * i +: 2] = (x >= y) ? 2'h3 : 2'h0;
				end
				USS_OP_BSUB: begin
					r |= (32'(d) & m) << (i * lw);
					f[i] = (x >= y);
				end
				default: r = r + ((x >= y) ? 32'(x - y) : 32'(y - x));
			endcase
		end
	endtask
	// One issue, judged one cycle later while the strobes stand.
	task automatic do_op(input logic [2:0] op, input logic cp, dg,
		input logic [3:0] d, n, m, a);
		logic [31:0] er;
		logic [3:0] ew;
		logic take;
		@(negedge sys_clk);
		issue = 1'b1;
		op_sel = op;
		cond_pass = cp;
		dest_given = dg;
		dest_reg = d;
		first_operand_reg = n;
		second_operand_reg = m;
		accumulate_reg = a;
		#1;
		ew = ef;
		calc(op, op_a, op_b, op_acc, er, ew);
		take = cp && op <= USS_OP_BSUB;
		@(negedge sys_clk);
		issue = 1'b0;
		chk("wr_en_r", 32'(take), wr_en_r);
		chk("flag_wr_r", 32'(take && op >= USS_OP_HSUB), flag_wr_r);
		if (take) begin
			ef = ew;
			chk("wr_reg_r", (dg || op == USS_OP_SADA) ? d : n, wr_reg_r);
			if (op == USS_OP_SAD || op == USS_OP_SADA) begin
				chk("wr_data_r", er, wr_data_r);
			end else begin
				chk("wr_data_r", er, wr_data_r);
			end
		end
		chk("lane_compare_flags_r", ef, lane_compare_flags_r);
	endtask
	// Every output must show its reset value while reset is held or just released.
	task automatic chk_reset();
		chk("wr_en_r", 32'h0, wr_en_r);
		chk("flag_wr_r", 32'h0, flag_wr_r);
		chk("wr_reg_r", 32'(USS_REG_RST), wr_reg_r);
		chk("wr_data_r", USS_RESULT_RST, wr_data_r);
		chk("lane_compare_flags_r", 32'(USS_FLAG_RST), lane_compare_flags_r);
	endtask
	// Reset in mid-run clears the outputs at once, without waiting for a clock edge.
	task automatic t_mid_reset();
		@(negedge sys_clk);
		rst_n = 1'b0;
		#1;
		chk_reset();
		ef = USS_FLAG_RST;
		@(negedge sys_clk);
		rst_n = 1'b1;
		chk_reset();
	endtask
	// Every code with a named destination; flag-setting codes first so holds are seen.
	task automatic t_every_op();
		for (int i = 0; i < 6; i++) begin
			do_op(3'((i + 4) % 6), 1'b1, 1'b1, 4'(i + 4), 4'h1, 4'h2, 4'h3);
		end
	endtask
	// Omitted destination falls back to the first operand, except for the accumulate sum.
	task automatic t_omitted_dest();
		do_op(USS_OP_BSUB, 1'b1, 1'b0, 4'hA, 4'h4, 4'h2, 4'h0);
		do_op(USS_OP_HBSUB, 1'b1, 1'b0, 4'hA, 4'h2, 4'h1, 4'h0);
		do_op(USS_OP_SADA, 1'b1, 1'b0, 4'hB, 4'h1, 4'h5, 4'h3);
	endtask
	// Failed condition and unused codes must leave result and flags alone.
	task automatic t_refused();
		do_op(USS_OP_BSUB, 1'b0, 1'b1, 4'h6, 4'h2, 4'h1, 4'h0);
		do_op(3'h6, 1'b1, 1'b1, 4'h6, 4'h2, 4'h1, 4'h0);
		do_op(3'h7, 1'b1, 1'b1, 4'h6, 4'h2, 4'h1, 4'h0);
		do_op(USS_OP_HSUB, 1'b1, 1'b1, 4'h7, 4'h2, 4'h1, 4'h0);
	endtask
	// A hang would otherwise never reach the verdict.
	initial begin
		#2000000;
		miscompares++;
		conclude();
	end
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	initial begin
		rst_n = 1'b0;
		issue = 1'b0;
		op_sel = 3'h0;
		cond_pass = 1'b0;
		dest_given = 1'b0;
		dest_reg = 4'h0;
		first_operand_reg = 4'h0;
		second_operand_reg = 4'h0;
		accumulate_reg = 4'h0;
		ef = USS_FLAG_RST;
		repeat (2) @(negedge sys_clk);
		rst_n = 1'b1;
		chk_reset();
		t_every_op();
		t_mid_reset();
		t_omitted_dest();
		t_refused();
		conclude();
	end
endmodule
`default_nettype wire
